// ### rtl/lbb_blink_timer.v
/*
 Blink phase generator: toggles a phase flag at a rate picked by the
 blink rate code. Assumes one 100 MHz clock and synchronous reset.
*/
`timescale 1ns/10ps
`default_nettype none
`include "lbb_defines.vh"

module lbb_blink_timer (
    input wire clock,
    input wire reset,
    input wire [1:0] blink_rate_field,
    output reg phase_q
);
    reg [23:0] count_q;
    reg [23:0] limit;

    always @* begin
        case (blink_rate_field)
            2'h1: limit = `LBB_BLINK_DIV1;
            2'h2: limit = `LBB_BLINK_DIV2;
            2'h3: limit = `LBB_BLINK_DIV3;
            default: limit = 24'h00_0000;
        endcase
    end

    always @(posedge clock) begin
        if (reset || blink_rate_field == `LBB_BLINK_OFF) begin
            count_q <= 24'h00_0000;
            phase_q <= 1'b0;
        end else if (count_q >= limit) begin
            count_q <= 24'h00_0000;
            phase_q <= ~phase_q;
        end else begin
            count_q <= count_q + 24'h00_0001;
        end
    end
endmodule // lbb_blink_timer

`default_nettype wire

// ### rtl/lbb_ctrl.v
/*
 Bank and blink command controller of a low-multiplex LCD driver.
 Takes bytes already framed by a serial slave front end, decodes the
 command stream and steers display RAM writes and reads.
 Assumes byte_valid pulses one cycle per byte; transfer_start pulses
 once at each new transfer before its first command byte.
 Display RAM has no reset; unwritten words read back unknown.
 Blink half periods are fixed counts of the logic clock.
 Every output is registered.
*/
`timescale 1ns/10ps
`default_nettype none
`include "lbb_defines.vh"

module lbb_ctrl (
    input wire clock,
    input wire reset,
    input wire transfer_start,
    input wire byte_valid,
    input wire [7:0] byte_data,
    input wire [4:0] ram_rd_addr,
    output reg [1:0] drive_mode_q,
    output reg display_enable_q,
    output reg bias_half_q,
    output reg input_bank_q,
    output reg output_bank_q,
    output reg alt_blink_q,
    output reg [1:0] blink_rate_field_q,
    output reg blink_blank_q,
    output reg [4:0] data_ptr_q,
    output reg [2:0] subaddr_q,
    output reg [3:0] ram_rd_data_q,
    output reg shown_bank_q
);
    reg in_cmd_q;
    wire [3:0] rd_bits;
    wire phase;
    wire blink_on;
    wire is_cmd;
    wire is_data;
    wire mux_hi;
    wire bank_cmd;
    wire blink_cmd;
    wire mode_cmd;
    wire ptr_cmd;
    wire dev_cmd;
    wire alt_eff;
    wire bank_ok;
    reg [3:0] wmask;
    reg [3:0] wbits;
    genvar g;

    assign is_cmd = byte_valid && in_cmd_q;
    assign is_data = byte_valid && !in_cmd_q;
    // 1:3 and 1:4 lose bank switching
    assign mux_hi = (drive_mode_q == `LBB_DRIVE_MUX3) || (drive_mode_q == `LBB_DRIVE_MUX4);
    assign bank_ok = !mux_hi;
    // Command patterns are disjoint; at most one decode fires
    assign bank_cmd = is_cmd &&
        byte_data[`LBB_BANK_PAT_HI:`LBB_BANK_PAT_LO] == `LBB_BANK_PAT;
    assign blink_cmd = is_cmd &&
        byte_data[`LBB_BLINK_PAT_HI:`LBB_BLINK_PAT_LO] == `LBB_BLINK_PAT;
    assign mode_cmd = is_cmd &&
        byte_data[`LBB_MODESET_HI:`LBB_MODESET_LO] == `LBB_MODESET_PAT;
    assign ptr_cmd = is_cmd && byte_data[`LBB_PTR_HI:`LBB_PTR_LO] == `LBB_PTR_PAT;
    assign dev_cmd = is_cmd && byte_data[`LBB_DEVSEL_HI:`LBB_DEVSEL_LO] == `LBB_DEVSEL_PAT;
    assign alt_eff = alt_blink_q && !mux_hi;
    // Any nonzero rate code means blinking
    assign blink_on = blink_rate_field_q != `LBB_BLINK_OFF;

    lbb_blink_timer u_timer (
        .clock(clock),
        .reset(reset),
        .blink_rate_field(blink_rate_field_q),
        .phase_q(phase)
    );

    // Filling order: bits per byte slot depend on drive mode
    always @* begin
        wmask = 4'h0;
        wbits = 4'h0;
        case (drive_mode_q)
            `LBB_DRIVE_STATIC: begin
                wmask = input_bank_q ? 4'h4 : 4'h1;
                wbits = {1'b0, byte_data[7], 1'b0, byte_data[7]};
            end
            `LBB_DRIVE_MUX2: begin
                wmask = input_bank_q ? 4'hc : 4'h3;
                wbits = {byte_data[7:6], byte_data[7:6]};
            end
            `LBB_DRIVE_MUX3: begin
                wmask = 4'h7;
                wbits = {1'b0, byte_data[7:5]};
            end
            default: begin
                wmask = 4'hf;
                wbits = byte_data[7:4];
            end
        endcase
    end

    // Command phase: bit 7 clear hands the rest to data
    always @(posedge clock) begin
        if (reset) begin
            in_cmd_q <= 1'b1;
        end else if (transfer_start) begin
            in_cmd_q <= 1'b1;
        end else if (is_cmd) begin
            in_cmd_q <= byte_data[`LBB_CONT_BIT];
        end
    end

    // Bank selection status
    always @(posedge clock) begin
        if (reset) begin
            input_bank_q <= 1'b0;
            output_bank_q <= 1'b0;
        end else if (bank_cmd && bank_ok) begin
            input_bank_q <= byte_data[`LBB_BANK_IN_BIT];
            output_bank_q <= byte_data[`LBB_BANK_OUT_BIT];
        end
    end

    // Blink mode and rate, held as written
    always @(posedge clock) begin
        if (reset) begin
            alt_blink_q <= 1'b0;
            blink_rate_field_q <= `LBB_RST_RATE;
        end else if (blink_cmd) begin
            alt_blink_q <= byte_data[`LBB_BLINK_MODE_BIT];
            blink_rate_field_q <= byte_data[`LBB_BLINK_RATE_HI:`LBB_BLINK_RATE_LO];
        end
    end

    // Mode-set status
    always @(posedge clock) begin
        if (reset) begin
            display_enable_q <= 1'b0;
            bias_half_q <= 1'b0;
            drive_mode_q <= `LBB_RST_DRIVE;
        end else if (mode_cmd) begin
            display_enable_q <= byte_data[`LBB_MODE_EN_BIT];
            bias_half_q <= byte_data[`LBB_MODE_BIAS_BIT];
            drive_mode_q <= byte_data[`LBB_MODE_HI:`LBB_MODE_LO];
        end
    end

    // Pointer and subaddress: loaded by command, stepped by data
    always @(posedge clock) begin
        if (reset) begin
            data_ptr_q <= `LBB_RST_PTR;
            subaddr_q <= `LBB_RST_SUBADDR;
        end else if (ptr_cmd) begin
            data_ptr_q <= byte_data[`LBB_PTR_VAL_HI:`LBB_PTR_VAL_LO];
        end else if (dev_cmd) begin
            subaddr_q <= byte_data[`LBB_SUBADDR_HI:`LBB_SUBADDR_LO];
        end else if (is_data) begin
            data_ptr_q <= data_ptr_q + 5'h01;
            if (data_ptr_q == `LBB_PTR_LAST) begin
                subaddr_q <= subaddr_q + 3'h1;
            end
        end
    end

    // One bit plane per RAM bit, each under its own write mask
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_plane
            reg plane_q [0:31];
            always @(posedge clock) begin
                if (is_data && wmask[g]) begin
                    plane_q[data_ptr_q] <= wbits[g];
                end
            end
            assign rd_bits[g] = plane_q[ram_rd_addr];
        end
    endgenerate

    // Displayed bank, toggled by alternate blinking
    always @(posedge clock) begin
        if (reset) begin
            shown_bank_q <= 1'b0;
        end else if (mux_hi) begin
            shown_bank_q <= 1'b0;
        end else if (alt_eff && blink_on) begin
            shown_bank_q <= output_bank_q ^ phase;
        end else begin
            shown_bank_q <= output_bank_q;
        end
    end

    // Normal blinking blanks on the off phase
    always @(posedge clock) begin
        if (reset) begin
            blink_blank_q <= 1'b0;
        end else begin
            blink_blank_q <= !alt_eff && blink_on && phase;
        end
    end

    // Registered RAM read, one cycle after the address
    always @(posedge clock) begin
        if (reset) begin
            ram_rd_data_q <= 4'h0;
        end else begin
            ram_rd_data_q <= rd_bits;
        end
    end
endmodule // lbb_ctrl

`default_nettype wire

// ### rtl/lbb_defines.vh
/*
 Constants for the bank and blink command controller: command patterns,
 field positions, drive mode codes, blink codes and reset values.
 Assumes inclusion by bare name from the design files.
*/
`ifndef LBB_DEFINES_VH
`define LBB_DEFINES_VH

`define LBB_CONT_BIT 7
`define LBB_BANK_PAT 5'h1e
`define LBB_BANK_PAT_HI 6
`define LBB_BANK_PAT_LO 2
`define LBB_BANK_IN_BIT 1
`define LBB_BANK_OUT_BIT 0
`define LBB_BLINK_PAT 4'he
`define LBB_BLINK_PAT_HI 6
`define LBB_BLINK_PAT_LO 3
`define LBB_BLINK_MODE_BIT 2
`define LBB_BLINK_RATE_HI 1
`define LBB_BLINK_RATE_LO 0
`define LBB_MODESET_PAT 2'h2
`define LBB_MODESET_HI 6
`define LBB_MODESET_LO 5
`define LBB_MODE_HI 1
`define LBB_MODE_LO 0
`define LBB_PTR_PAT 2'h0
`define LBB_DEVSEL_PAT 4'hc
`define LBB_MODE_EN_BIT 3
`define LBB_MODE_BIAS_BIT 2
`define LBB_PTR_HI 6
`define LBB_PTR_LO 5
`define LBB_PTR_VAL_HI 4
`define LBB_PTR_VAL_LO 0
`define LBB_PTR_LAST 5'h1f
`define LBB_DEVSEL_HI 6
`define LBB_DEVSEL_LO 3
`define LBB_SUBADDR_HI 2
`define LBB_SUBADDR_LO 0
`define LBB_DRIVE_STATIC 2'h1
`define LBB_DRIVE_MUX2 2'h2
`define LBB_DRIVE_MUX3 2'h3
`define LBB_DRIVE_MUX4 2'h0
`define LBB_BLINK_OFF 2'h0
`define LBB_RST_DRIVE 2'h1
`define LBB_RST_RATE 2'h0
`define LBB_RST_PTR 5'h00
`define LBB_RST_SUBADDR 3'h0
`define LBB_BLINK_DIV1 24'h07_a120
`define LBB_BLINK_DIV2 24'h0f_4240
`define LBB_BLINK_DIV3 24'h1e_8480

`endif

// ### verification/lbb_ctrl_properties.sv
/* Checker of bank and blink command decoding.
   Assumes binding onto lbb_ctrl; sees its ports only. */
`timescale 1ns/10ps
`default_nettype none
module lbb_ctrl_properties (
    input wire logic clock,
    input wire logic reset,
    input wire logic transfer_start,
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    input wire logic [1:0] drive_mode_q,
    input wire logic input_bank_q,
    input wire logic output_bank_q,
    input wire logic alt_blink_q,
    input wire logic [1:0] blink_rate_field_q,
    input wire logic blink_blank_q,
    input wire logic [4:0] data_ptr_q,
    input wire logic shown_bank_q
);
    logic cmd_q;
    logic bank_w, blink_w, fix_w;
    // Command phase of the transfer
    always_ff @(posedge clock) begin
        if (reset || transfer_start)
            cmd_q <= 1'b1;
        else if (byte_valid && !byte_data[7])
            cmd_q <= 1'b0;
    end
    assign bank_w = byte_valid && cmd_q && byte_data[6:2] == 5'h1e;
    assign blink_w = byte_valid && cmd_q && byte_data[6:3] == 4'he;
    assign fix_w = drive_mode_q[1] == drive_mode_q[0];
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    sequence mux_held;
        fix_w [*3];
    endsequence
    sequence dual_off;
        (!fix_w && blink_rate_field_q == 2'h0 && $stable(output_bank_q)) [*3];
    endsequence
    bank_sel_a: assert property (bank_w && !fix_w |=>
        {input_bank_q, output_bank_q} == $past(byte_data[1:0])) else $error("bank not taken");
    bank_ign_a: assert property (bank_w && fix_w |=>
        $stable(input_bank_q) && $stable(output_bank_q)) else $error("bank not ignored");
    blink_sel_a: assert property (blink_w |=>
        {alt_blink_q, blink_rate_field_q} == $past(byte_data[2:0])) else $error("blink wrong");
    mux_shown_a: assert property (mux_held |-> !shown_bank_q)
        else $error("mux shows bank one");
    off_shown_a: assert property (dual_off |-> shown_bank_q == output_bank_q && !blink_blank_q)
        else $error("steady display wrong");
    data_ptr_a: assert property (byte_valid && !cmd_q |=> data_ptr_q == $past(data_ptr_q) + 5'h1)
        else $error("pointer not advanced");
    data_hold_a: assert property (byte_valid && !cmd_q |=>
        $stable(drive_mode_q) && $stable(output_bank_q)) else $error("data taken as command");
    reset_val_a: assert property ($fell(reset) |-> drive_mode_q == 2'h1)
        else $error("drive reset wrong");
endmodule // lbb_ctrl_properties
bind lbb_ctrl lbb_ctrl_properties u_props (.clock(clock), .reset(reset),
    .transfer_start(transfer_start), .byte_valid(byte_valid), .byte_data(byte_data),
    .drive_mode_q(drive_mode_q), .input_bank_q(input_bank_q), .output_bank_q(output_bank_q),
    .alt_blink_q(alt_blink_q), .blink_rate_field_q(blink_rate_field_q),
    .blink_blank_q(blink_blank_q), .data_ptr_q(data_ptr_q), .shown_bank_q(shown_bank_q));
`default_nettype wire

// ### verification/lbb_host_model.sv
/* Host side model: frames transfers and hands bytes over.
   Assumes one clock shared with the controller. */
`timescale 1ns/10ps
`default_nettype none
module lbb_host_model (
    input wire logic clock,
    output logic transfer_start,
    output logic byte_valid,
    output logic [7:0] byte_data
);
    initial begin
        transfer_start = 1'b0;
        byte_valid = 1'b0;
        byte_data = 8'h00;
    end
    task start;
        @(posedge clock);
        #1 transfer_start = 1'b1;
        @(posedge clock);
        #1 transfer_start = 1'b0;
    endtask
    // Caller sets bit 7 on every command but the last
    task send(input logic [7:0] b);
        @(posedge clock);
        #1 byte_valid = 1'b1;
        byte_data = b;
        @(posedge clock);
        #1 byte_valid = 1'b0;
        byte_data = ~b;
    endtask
endmodule // lbb_host_model
`default_nettype wire

// ### verification/tb.sv
/* Self-checking bench for the bank and blink controller.
   Assumes the host model feeds already framed bytes. */
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clock, reset, transfer_start, byte_valid;
    logic [7:0] byte_data, r;
    logic [4:0] ram_rd_addr, data_ptr_q;
    logic [1:0] drive_mode_q, blink_rate_field_q;
    logic [3:0] ram_rd_data_q;
    logic input_bank_q, output_bank_q, alt_blink_q, blink_blank_q, shown_bank_q;
    logic display_enable_q, bias_half_q;
    logic [2:0] subaddr_q;
    int bad_count = 0;
    int num_checks = 0;
    lbb_ctrl u_dut (.clock(clock), .reset(reset), .transfer_start(transfer_start),
        .byte_valid(byte_valid), .byte_data(byte_data), .ram_rd_addr(ram_rd_addr),
        .drive_mode_q(drive_mode_q), .display_enable_q(display_enable_q),
        .bias_half_q(bias_half_q),
        .input_bank_q(input_bank_q), .output_bank_q(output_bank_q), .alt_blink_q(alt_blink_q),
        .blink_rate_field_q(blink_rate_field_q), .blink_blank_q(blink_blank_q),
        .data_ptr_q(data_ptr_q), .subaddr_q(subaddr_q), .ram_rd_data_q(ram_rd_data_q),
        .shown_bank_q(shown_bank_q));
    lbb_host_model u_host (.clock(clock), .transfer_start(transfer_start),
        .byte_valid(byte_valid), .byte_data(byte_data));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        #200000;
        bad_count++;
        give_verdict;
    end
    initial begin
        reset = 1'b1;
        ram_rd_addr = 5'h00;
        tick(16);
        reset = 1'b0;
        chk(drive_mode_q, 2'h1, "drive");
        chk({input_bank_q, output_bank_q, shown_bank_q}, 3'h0, "banks");
        $display("test reset done");
        u_host.start;
        u_host.send(8'hc9);
        u_host.send(8'he5);
        u_host.send(8'h83);
        u_host.send(8'h7b);
        chk({input_bank_q, output_bank_q}, 2'h3, "bank select");
        chk({display_enable_q, bias_half_q}, 2'h2, "mode status");
        chk(subaddr_q, 3'h5, "subaddress");
        u_host.send(8'h80);
        u_host.send(8'h78);
        chk(data_ptr_q, 5'h05, "pointer");
        chk({input_bank_q, output_bank_q}, 2'h3, "data as command");
        for (r = 8'h03; r < 8'h05; r++) begin
            ram_rd_addr = r[4:0];
            tick(2);
            chk(ram_rd_data_q[2], r == 8'h03, "fill bit");
        end
        $display("test bank done");
        u_host.start;
        u_host.send(8'hcc);
        u_host.send(8'h9f);
        u_host.send(8'h78);
        u_host.send(8'ha0);
        chk({input_bank_q, output_bank_q}, 2'h3, "ignored bank");
        chk(drive_mode_q, 2'h0, "drive 1:4");
        chk(bias_half_q, 1'b1, "bias");
        chk({subaddr_q, data_ptr_q}, 8'hc0, "pointer wrap");
        ram_rd_addr = 5'h1f;
        tick(2);
        chk(ram_rd_data_q, 4'ha, "mux4 fill");
        u_host.start;
        u_host.send(8'h76);
        chk({alt_blink_q, blink_rate_field_q}, 3'h6, "blink");
        tick(3);
        chk(shown_bank_q, 1'b0, "mux shown");
        for (r = 8'h73; r >= 8'h70; r--) begin
            u_host.start;
            u_host.send(8'hc9);
            u_host.send(8'hf9);
            u_host.send(r);
            chk(blink_rate_field_q, r[1:0], "rate");
        end
        tick(3);
        chk(shown_bank_q, 1'b1, "steady shown");
        $display("test blink done");
        give_verdict;
    end
endmodule // tb
`default_nettype wire
